// File: src/cfg_load_pkg.sv
// package: constants, states and carriers of the configuration loader
package cfg_load_pkg;
    // core clock rate
    localparam int CORE_MHZ            = 100;
    // printed times, each in its own unit
    localparam int POR_US              = 100;
    localparam int STATUS_MIN_US       = 45;
    localparam int STATUS_MAX_US       = 230;
    localparam int REQ2DONE_MAX_NS     = 500;
    localparam int CD2UM_MIN_US        = 300;
    localparam int CD2UM_MAX_US        = 650;
    localparam int BYTE_CLK_MAX_PER_NS = 15;
    localparam int CD2CU_PERIODS       = 4;
    localparam int USER_INIT_EDGES     = 3192;
    localparam int INIT_FALL_EDGES     = 2;
    // cycle counts; whole microseconds times MHz are whole cycles
    localparam int POR_CYC        = POR_US * CORE_MHZ;
    localparam int STATUS_LOW_CYC = STATUS_MIN_US * CORE_MHZ;
    localparam int STATUS_MAX_CYC = STATUS_MAX_US * CORE_MHZ;
    localparam int REQ2DONE_CYC   = REQ2DONE_MAX_NS * CORE_MHZ / 1000;
    localparam int USER_MODE_CYC  = CD2UM_MIN_US * CORE_MHZ;
    localparam int USER_MAX_CYC   = CD2UM_MAX_US * CORE_MHZ;
    localparam int CD2CU_CYC      =
        (CD2CU_PERIODS * BYTE_CLK_MAX_PER_NS * CORE_MHZ + 999) / 1000;
    // width of the core timers
    localparam int CNT_W          = 24;
    // scheme select code of the active serial scheme
    localparam logic [2:0] SEL_ACTIVE_SERIAL = 3'h1;
    // reset values of the pin drivers
    localparam logic STATUS_OE_RST = 1'h1;
    localparam logic DONE_OE_RST   = 1'h1;

    // loader sequence states
    typedef enum logic [5:0] {
        ST_POR   = 6'h01,
        ST_RESET = 6'h02,
        ST_LOAD  = 6'h04,
        ST_INIT  = 6'h08,
        ST_USER  = 6'h10,
        ST_JTAG  = 6'h20
    } cfg_state_t;

    // test access port states
    typedef enum logic [15:0] {
        TAP_TLR    = 16'h0001,
        TAP_RTI    = 16'h0002,
        TAP_SEL_DR = 16'h0004,
        TAP_CAP_DR = 16'h0008,
        TAP_SH_DR  = 16'h0010,
        TAP_EX1_DR = 16'h0020,
        TAP_PA_DR  = 16'h0040,
        TAP_EX2_DR = 16'h0080,
        TAP_UPD_DR = 16'h0100,
        TAP_SEL_IR = 16'h0200,
        TAP_CAP_IR = 16'h0400,
        TAP_SH_IR  = 16'h0800,
        TAP_EX1_IR = 16'h1000,
        TAP_PA_IR  = 16'h2000,
        TAP_EX2_IR = 16'h4000,
        TAP_UPD_IR = 16'h8000
    } tap_state_t;

    // every level that enters the core clock domain, except the user data and reset
    typedef struct packed {
        logic       req_n;
        logic       st_n;
        logic       uclk;
        logic       use_uclk;
        logic [2:0] sel;
        logic       dual;
        logic       tck;
        logic       tms;
        logic       tdi;
        logic       link_done;
        logic       init_go;
    } pin_sync_t;
endpackage

// File: src/cfg_load_seq.sv
// top: parallel configuration load sequencer with boundary-scan override
// Functional notes
// RULE_01: in user mode request, status and done lines high; low request restarts
// RULE_02: status line held low through the whole power-on delay
// RULE_03: done line low from power-up until loading has succeeded
// RULE_04: host keeps byte clock driven at a fixed level after loading
// RULE_05: data pins become user pins, driven per dual-purpose setting
// RULE_06: host holds request low at least 500 ns
// RULE_07: done line driven low within 500 ns of request falling
// RULE_08: status low pulse lasts 45 to 230 us on a reset
// RULE_09: status released within 230 us of request rising
// RULE_10: user init clock counted only after four longest byte periods
// RULE_11: internal timing reaches user mode 300 to 650 us after done
// RULE_12: host keeps byte clock at or below its maximum rate
// RULE_13: boundary-scan load overrides any scheme, at any time
// RULE_14: no config clock output during boundary-scan in active serial
// RULE_15: user pins high-impedance during boundary-scan load
// RULE_16: test data sampled on each test clock rising edge
// RULE_17: test output updates on falling edges, idle high-impedance
// RULE_18: test mode select steps the port state machine on rising edges
// RULE_19: one config byte captured per byte clock rising edge
// RULE_20: done rises one byte before the final byte arrives
// RULE_21: host gives two byte clock falling edges after done rises
// RULE_22: user init clock needs 3,192 cycles before user mode
// RULE_23: host waits for status high and keeps data steady
`timescale 1ns/100ps
module cfg_load_seq #(
    parameter int POR_CYC        = cfg_load_pkg::POR_CYC,
    parameter int STATUS_LOW_CYC = cfg_load_pkg::STATUS_LOW_CYC,
    parameter int USER_MODE_CYC  = cfg_load_pkg::USER_MODE_CYC,
    parameter int IMAGE_BYTES    = 1024,
    parameter int IR_W           = 4,
    parameter int DR_W           = 32,
    parameter int LOAD_IR        = 2
) (
    input  wire logic       CORE_CLK_I,
    input  wire logic       SYS_RST_I,
    input  wire logic       CFG_BYTE_CLK_I,
    input  wire logic [7:0] CFG_DATA_I,
    input  wire logic       CFG_REQ_N_I,
    input  wire logic       STATUS_N_I,
    input  wire logic       USER_INIT_CLK_I,
    input  wire logic       USE_USER_CLK_I,
    input  wire logic [2:0] SCHEME_SEL_I,
    input  wire logic       DUAL_PURPOSE_I,
    input  wire logic [7:0] USER_DATA_I,
    input  wire logic       TCK_I,
    input  wire logic       TMS_I,
    input  wire logic       TDI_I,
    output logic            STATUS_N_O,
    output logic            STATUS_N_OE_O,
    output logic            LOAD_DONE_O,
    output logic            LOAD_DONE_OE_O,
    output logic [7:0]      CFG_DATA_O,
    output logic [7:0]      CFG_DATA_OE_O,
    output logic            USER_IO_EN_O,
    output logic            USER_MODE_O,
    output logic            CFG_CLK_O,
    output logic            CFG_CLK_OE_O,
    output logic [7:0]      CFG_BYTE_O,
    output logic            CFG_BYTE_VLD_O,
    output logic            TDO_O,
    output logic            TDO_OE_O
);
    localparam int CW   = cfg_load_pkg::CNT_W;
    localparam int LK_W = $clog2(IMAGE_BYTES + 1);

    // parameters the counters cannot serve are refused
    if (IMAGE_BYTES < 2 || POR_CYC < 1 || STATUS_LOW_CYC < 1 ||
        USER_MODE_CYC <= cfg_load_pkg::CD2CU_CYC ||
        POR_CYC >= 2**CW || IR_W < 2 || DR_W < 1 ||
        USER_MODE_CYC >= 2**CW || STATUS_LOW_CYC >= 2**CW ||
        LOAD_IR >= 2**IR_W) begin : g_bad
        $error("cfg_load_seq: unsupported parameter values");
    end

    cfg_load_pkg::pin_sync_t  pins, sy1_q, sy;
    cfg_load_pkg::cfg_state_t state_q, state_d;
    cfg_load_pkg::tap_state_t tap_q, tap_d;
    logic [CW-1:0]   cnt_q, cnt_d, ucnt_q, ucnt_d;
    logic            jt_src_q, jt_src_d, tck_prev_q, uclk_prev_q;
    logic            status_oe_d, done_oe_d, io_en_d, clk_oe_d, clk_d;
    logic            link_clr_q, link_clr_d, jtag_act;
    logic [IR_W-1:0] ir_q, ir_d, ir_sh_q, ir_sh_d;
    logic [DR_W-1:0] dr_sh_q, dr_sh_d;
    logic            byp_q, byp_d, tdo_d, tdo_oe_d, tck_rise, tck_fall;
    logic            uclk_rise;
    logic [LK_W-1:0] lk_cnt_q, lk_cnt_d;
    logic            lk_done_q, lk_done_d, lk_vld_d;
    logic [1:0]      fe_cnt_q, fe_cnt_d;
    logic            go_q, go_d;

    // every pin and link level but user data and reset crosses through two flops before use
    assign pins = '{req_n: CFG_REQ_N_I, st_n: STATUS_N_I,
                    uclk: USER_INIT_CLK_I, use_uclk: USE_USER_CLK_I,
                    sel: SCHEME_SEL_I, dual: DUAL_PURPOSE_I, tck: TCK_I,
                    tms: TMS_I, tdi: TDI_I, link_done: lk_done_q,
                    init_go: go_q};
    always_ff @(posedge CORE_CLK_I) begin
        sy1_q       <= pins;
        sy          <= sy1_q;
        tck_prev_q  <= sy.tck;
        uclk_prev_q <= sy.uclk;
    end

    // edges come from the second stage and a third flop only
    assign tck_rise  = sy.tck & ~tck_prev_q;
    assign tck_fall  = ~sy.tck & tck_prev_q;
    assign uclk_rise = sy.uclk & ~uclk_prev_q;
    assign jtag_act  = (ir_q == IR_W'(LOAD_IR));

    // port state machine step on test mode select
    function automatic cfg_load_pkg::tap_state_t tap_next(
        input cfg_load_pkg::tap_state_t s, input logic tms);
        case (s)
            cfg_load_pkg::TAP_TLR:    tap_next = tms ? s : cfg_load_pkg::TAP_RTI;
            cfg_load_pkg::TAP_RTI:    tap_next = tms ? cfg_load_pkg::TAP_SEL_DR : s;
            cfg_load_pkg::TAP_SEL_DR: tap_next = tms ? cfg_load_pkg::TAP_SEL_IR
                                                     : cfg_load_pkg::TAP_CAP_DR;
            cfg_load_pkg::TAP_CAP_DR,
            cfg_load_pkg::TAP_SH_DR,
            cfg_load_pkg::TAP_EX2_DR: tap_next = tms ? cfg_load_pkg::TAP_EX1_DR
                                                     : cfg_load_pkg::TAP_SH_DR;
            cfg_load_pkg::TAP_EX1_DR: tap_next = tms ? cfg_load_pkg::TAP_UPD_DR
                                                     : cfg_load_pkg::TAP_PA_DR;
            cfg_load_pkg::TAP_PA_DR:  tap_next = tms ? cfg_load_pkg::TAP_EX2_DR : s;
            cfg_load_pkg::TAP_SEL_IR: tap_next = tms ? cfg_load_pkg::TAP_TLR
                                                     : cfg_load_pkg::TAP_CAP_IR;
            cfg_load_pkg::TAP_CAP_IR,
            cfg_load_pkg::TAP_SH_IR,
            cfg_load_pkg::TAP_EX2_IR: tap_next = tms ? cfg_load_pkg::TAP_EX1_IR
                                                     : cfg_load_pkg::TAP_SH_IR;
            cfg_load_pkg::TAP_EX1_IR: tap_next = tms ? cfg_load_pkg::TAP_UPD_IR
                                                     : cfg_load_pkg::TAP_PA_IR;
            cfg_load_pkg::TAP_PA_IR:  tap_next = tms ? cfg_load_pkg::TAP_EX2_IR : s;
            default:                  tap_next = tms ? cfg_load_pkg::TAP_SEL_DR
                                                     : cfg_load_pkg::TAP_RTI;
        endcase
    endfunction

    // boundary-scan port: shift on rise, drive test output on fall
    always_comb begin
        tap_d    = tap_q;
        ir_d     = ir_q;
        ir_sh_d  = ir_sh_q;
        dr_sh_d  = dr_sh_q;
        byp_d    = byp_q;
        tdo_d    = TDO_O;
        tdo_oe_d = TDO_OE_O;
        if (tck_rise) begin
            // RULE_18: mode select steps
            tap_d = tap_next(tap_q, sy.tms);
            // RULE_16: rising edge sampling
            case (tap_q)
                cfg_load_pkg::TAP_TLR:    ir_d    = '1;
                cfg_load_pkg::TAP_CAP_IR: ir_sh_d = IR_W'(1);
                cfg_load_pkg::TAP_SH_IR:  ir_sh_d = {sy.tdi, ir_sh_q[IR_W-1:1]};
                cfg_load_pkg::TAP_UPD_IR: ir_d    = ir_sh_q;
                cfg_load_pkg::TAP_CAP_DR: byp_d   = 1'b0;
                cfg_load_pkg::TAP_SH_DR: begin
                    if (jtag_act) begin
                        dr_sh_d = {sy.tdi, dr_sh_q[DR_W-1:1]};
                    end else begin
                        byp_d = sy.tdi;
                    end
                end
                default: ;
            endcase
        end
        // RULE_17: falling edge output, idle off
        if (tck_fall) begin
            tdo_oe_d = (tap_q == cfg_load_pkg::TAP_SH_IR) ||
                       (tap_q == cfg_load_pkg::TAP_SH_DR);
            tdo_d    = (tap_q == cfg_load_pkg::TAP_SH_IR) ? ir_sh_q[0] :
                       jtag_act ? dr_sh_q[0] : byp_q;
        end
    end

    // loader sequence: power-on, reset pulse, load, init, user
    always_comb begin
        state_d  = state_q;
        cnt_d    = cnt_q;
        ucnt_d   = ucnt_q;
        jt_src_d = jt_src_q;
        case (state_q)
            // RULE_02: status low over power-on
            cfg_load_pkg::ST_POR: begin
                if (cnt_q >= CW'(POR_CYC - 1)) begin
                    state_d = sy.req_n ? cfg_load_pkg::ST_LOAD
                                       : cfg_load_pkg::ST_RESET;
                    cnt_d   = '0;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            // RULE_08: least pulse then RULE_09 release
            cfg_load_pkg::ST_RESET: begin
                if (cnt_q < CW'(STATUS_LOW_CYC - 1)) begin
                    cnt_d = cnt_q + 1'b1;
                end else if (sy.req_n) begin
                    state_d = cfg_load_pkg::ST_LOAD;
                end
            end
            // RULE_20: early done seen from link
            cfg_load_pkg::ST_LOAD: begin
                if (sy.link_done) begin
                    state_d  = cfg_load_pkg::ST_INIT;
                    cnt_d    = '0;
                    ucnt_d   = '0;
                    jt_src_d = 1'b0;
                end
            end
            cfg_load_pkg::ST_INIT: begin
                if (cnt_q < CW'(USER_MODE_CYC)) begin
                    cnt_d = cnt_q + 1'b1;
                end
                // RULE_21: wait for host falling edges
                if (sy.init_go || jt_src_q) begin
                    if (sy.use_uclk) begin
                        // RULE_10: user clock gated by delay
                        if (uclk_rise && cnt_q >= CW'(cfg_load_pkg::CD2CU_CYC))
                            ucnt_d = ucnt_q + 1'b1;
                        // RULE_22: counted user clock cycles
                        if (ucnt_q >= CW'(cfg_load_pkg::USER_INIT_EDGES))
                            state_d = cfg_load_pkg::ST_USER;
                    // RULE_11: internal oscillator timing
                    end else if (cnt_q >= CW'(USER_MODE_CYC - 1)) begin
                        state_d = cfg_load_pkg::ST_USER;
                    end
                end
            end
            cfg_load_pkg::ST_USER: ;
            cfg_load_pkg::ST_JTAG: begin
                if (!jtag_act) begin
                    state_d  = cfg_load_pkg::ST_INIT;
                    cnt_d    = '0;
                    ucnt_d   = '0;
                    jt_src_d = 1'b1;
                end
            end
            default: state_d = cfg_load_pkg::ST_POR;
        endcase
        // RULE_13: boundary-scan load wins at any time
        if (jtag_act && state_q != cfg_load_pkg::ST_JTAG) begin
            state_d = cfg_load_pkg::ST_JTAG;
        // RULE_01: low request restarts loading
        end else if (!sy.req_n && (state_q == cfg_load_pkg::ST_LOAD ||
                     state_q == cfg_load_pkg::ST_INIT ||
                     state_q == cfg_load_pkg::ST_USER)) begin
            state_d = cfg_load_pkg::ST_RESET;
            cnt_d   = '0;
        end
        // pin drivers follow the next state so they switch with it
        status_oe_d = (state_d == cfg_load_pkg::ST_POR) ||
                      (state_d == cfg_load_pkg::ST_RESET);
        // RULE_03: done low until success; RULE_07 done low on request
        done_oe_d   = (state_d != cfg_load_pkg::ST_INIT) &&
                      (state_d != cfg_load_pkg::ST_USER);
        // RULE_15: user pins off during boundary-scan
        io_en_d     = (state_d == cfg_load_pkg::ST_USER);
        // RULE_14: no clock output while scan loads
        clk_oe_d    = (state_d == cfg_load_pkg::ST_LOAD) &&
                      (sy.sel == cfg_load_pkg::SEL_ACTIVE_SERIAL);
        clk_d       = clk_oe_d & ~CFG_CLK_O;
        // bytes are refused until the status line really reads high; the
        // link stays live in init after a byte load, not after a scan load, so the last byte and its edges still count
        link_clr_d  = !((state_d == cfg_load_pkg::ST_LOAD && sy.st_n) ||
                        (state_d == cfg_load_pkg::ST_INIT && !jt_src_d));
    end

    // core registers
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            state_q        <= cfg_load_pkg::ST_POR;
            cnt_q          <= '0;
            ucnt_q         <= '0;
            jt_src_q       <= 1'b0;
            tap_q          <= cfg_load_pkg::TAP_TLR;
            ir_q           <= '1;
            ir_sh_q        <= '0;
            dr_sh_q        <= '0;
            byp_q          <= 1'b0;
            TDO_O          <= 1'b0;
            TDO_OE_O       <= 1'b0;
            STATUS_N_OE_O  <= cfg_load_pkg::STATUS_OE_RST;
            LOAD_DONE_OE_O <= cfg_load_pkg::DONE_OE_RST;
            STATUS_N_O     <= 1'b0;
            LOAD_DONE_O    <= 1'b0;
            USER_IO_EN_O   <= 1'b0;
            USER_MODE_O    <= 1'b0;
            CFG_DATA_O     <= '0;
            CFG_DATA_OE_O  <= '0;
            CFG_CLK_O      <= 1'b0;
            CFG_CLK_OE_O   <= 1'b0;
            link_clr_q     <= 1'b1;
        end else begin
            state_q        <= state_d;
            cnt_q          <= cnt_d;
            ucnt_q         <= ucnt_d;
            jt_src_q       <= jt_src_d;
            tap_q          <= tap_d;
            ir_q           <= ir_d;
            ir_sh_q        <= ir_sh_d;
            dr_sh_q        <= dr_sh_d;
            byp_q          <= byp_d;
            TDO_O          <= tdo_d;
            TDO_OE_O       <= tdo_oe_d;
            STATUS_N_OE_O  <= status_oe_d;
            LOAD_DONE_OE_O <= done_oe_d;
            STATUS_N_O     <= 1'b0;    // open drain: only ever pulls low
            LOAD_DONE_O    <= 1'b0;
            USER_IO_EN_O   <= io_en_d;
            USER_MODE_O    <= io_en_d;
            // RULE_05: data pins per dual-purpose setting
            CFG_DATA_O     <= USER_DATA_I;
            CFG_DATA_OE_O  <= {8{io_en_d & sy.dual}};
            CFG_CLK_O      <= clk_d;
            CFG_CLK_OE_O   <= clk_oe_d;
            link_clr_q     <= link_clr_d;
        end
    end

    // link side: byte count; the byte clock may stop, so clear is async
    always_comb begin
        lk_cnt_d  = lk_cnt_q;
        lk_done_d = lk_done_q;
        lk_vld_d  = lk_cnt_q < LK_W'(IMAGE_BYTES);
        if (lk_vld_d) begin
            lk_cnt_d = lk_cnt_q + 1'b1;
        end
        // RULE_20: done raised one byte early
        if (lk_cnt_q == LK_W'(IMAGE_BYTES - 2)) begin
            lk_done_d = 1'b1;
        end
        fe_cnt_d = fe_cnt_q;
        if (lk_done_q && fe_cnt_q < 2'(cfg_load_pkg::INIT_FALL_EDGES)) begin
            fe_cnt_d = fe_cnt_q + 1'b1;
        end
        go_d = (fe_cnt_d == 2'(cfg_load_pkg::INIT_FALL_EDGES));
    end

    // RULE_19: byte captured on each rising edge until IMAGE_BYTES have arrived
    always_ff @(posedge CFG_BYTE_CLK_I or posedge link_clr_q) begin
        if (link_clr_q) begin
            lk_cnt_q       <= '0;
            lk_done_q      <= 1'b0;
            CFG_BYTE_O     <= '0;
            CFG_BYTE_VLD_O <= 1'b0;
        end else begin
            lk_cnt_q       <= lk_cnt_d;
            lk_done_q      <= lk_done_d;
            CFG_BYTE_O     <= lk_vld_d ? CFG_DATA_I : CFG_BYTE_O;
            CFG_BYTE_VLD_O <= lk_vld_d;
        end
    end

    // RULE_21: falling edges after done start init
    always_ff @(negedge CFG_BYTE_CLK_I or posedge link_clr_q) begin
        if (link_clr_q) begin
            fe_cnt_q <= '0;
            go_q     <= 1'b0;
        end else begin
            fe_cnt_q <= fe_cnt_d;
            go_q     <= go_d;
        end
    end

    sequence s_req_fall;
        $fell(sy.req_n);
    endsequence
    sequence s_tck_fall_idle;
        tck_fall && tap_q != cfg_load_pkg::TAP_SH_IR &&
        tap_q != cfg_load_pkg::TAP_SH_DR;
    endsequence

    a_por_status_low: assert property (@(posedge CORE_CLK_I) // RULE_02
        $fell(SYS_RST_I) |-> STATUS_N_OE_O [*8])
        else $error("status released during power-on delay");
    a_done_held_low: assert property (@(posedge CORE_CLK_I) // RULE_03
        disable iff (SYS_RST_I)
        state_q == cfg_load_pkg::ST_LOAD |-> LOAD_DONE_OE_O)
        else $error("done released while loading");
    a_req_drops_done: assert property (@(posedge CORE_CLK_I) // RULE_07
        disable iff (SYS_RST_I) s_req_fall ##0 !jtag_act
        |-> ##[1:2] (LOAD_DONE_OE_O && STATUS_N_OE_O))
        else $error("request fall did not pull done and status low");
    a_status_pulse_min: assert property (@(posedge CORE_CLK_I) // RULE_08
        disable iff (SYS_RST_I)
        $fell(STATUS_N_OE_O) && state_q == cfg_load_pkg::ST_LOAD &&
        $past(state_q == cfg_load_pkg::ST_RESET)
        |-> $past(cnt_q) >= CW'(STATUS_LOW_CYC - 1))
        else $error("status low pulse too short");
    a_status_release: assert property (@(posedge CORE_CLK_I) // RULE_09
        disable iff (SYS_RST_I)
        state_q == cfg_load_pkg::ST_RESET && sy.req_n && !jtag_act &&
        cnt_q >= CW'(STATUS_LOW_CYC - 1) |=> !STATUS_N_OE_O)
        else $error("status not released after request high");
    a_uclk_gated: assert property (@(posedge CORE_CLK_I) // RULE_10
        disable iff (SYS_RST_I)
        state_q == cfg_load_pkg::ST_INIT &&
        cnt_q < CW'(cfg_load_pkg::CD2CU_CYC) |=> ucnt_q == '0)
        else $error("user init clock counted too early");
    a_scan_override: assert property (@(posedge CORE_CLK_I) // RULE_13
        disable iff (SYS_RST_I)
        jtag_act |=> state_q == cfg_load_pkg::ST_JTAG && LOAD_DONE_OE_O)
        else $error("boundary-scan load did not take over");
    a_scan_pins_off: assert property (@(posedge CORE_CLK_I) // RULE_15
        disable iff (SYS_RST_I)
        state_q == cfg_load_pkg::ST_JTAG |-> !USER_IO_EN_O &&
        CFG_DATA_OE_O == '0 && !CFG_CLK_OE_O)
        else $error("pins driven during boundary-scan load");
    a_tdo_idle_off: assert property (@(posedge CORE_CLK_I) // RULE_17
        disable iff (SYS_RST_I) s_tck_fall_idle |=> !TDO_OE_O)
        else $error("test output driven while not shifting");
    a_done_early: assert property (@(posedge CFG_BYTE_CLK_I) // RULE_20
        disable iff (link_clr_q)
        lk_cnt_q == LK_W'(IMAGE_BYTES - 2) |=> lk_done_q && CFG_BYTE_VLD_O)
        else $error("done not raised one byte early");
endmodule

// File: testbench/cfg_host.sv
// host model: presents config bytes and the byte clock
`timescale 1ns/100ps
module cfg_host (
    input  wire logic       status_i,
    output logic            bclk_o,
    output logic [7:0]      data_o
);
    // clock parked low and data quiet until the first frame
    initial begin
        bclk_o = 1'b0;
        data_o = 8'h00;
    end
    // waits, 6 ns period, parked clock
    task automatic send(input logic [7:0] b);
        wait (status_i === 1'b1);
        data_o = b;
        #3 bclk_o = 1'b1;
        #3 bclk_o = 1'b0;
        data_o = ~b; // no stale byte once the edge is past
    endtask
endmodule

// File: testbench/cfg_load_seq_tb.sv
// testbench: power-on, byte load, init and reconfiguration
`timescale 1ns/100ps
module cfg_load_seq_tb;
    logic        clk, rst, req_n, uclk;
    logic        tck, tms, tdi, use_uclk, dual;
    logic [2:0]  sel;
    logic [7:0]  udata, last;
    logic [31:0] rnd;
    logic [8:0]  exp_q[$];
    int          n_errors, samples_checked;
    wire         bclk, st_oe, dn_oe, umode, uio;
    wire         vld, clk_oe, tdo, tdo_oe;
    wire  [7:0]  data, data_o, data_oe, cfg_byte;
    cfg_load_seq #(.POR_CYC(20), .STATUS_LOW_CYC(10), .USER_MODE_CYC(40),
        .IMAGE_BYTES(8)) i_dut (.CORE_CLK_I(clk), .SYS_RST_I(rst),
        .CFG_BYTE_CLK_I(bclk), .CFG_DATA_I(data), .CFG_REQ_N_I(req_n),
        .STATUS_N_I(~st_oe), .USER_INIT_CLK_I(uclk),
        .USE_USER_CLK_I(use_uclk), .SCHEME_SEL_I(sel),
        .DUAL_PURPOSE_I(dual), .USER_DATA_I(udata),
        .TCK_I(tck), .TMS_I(tms), .TDI_I(tdi), .STATUS_N_O(),
        .STATUS_N_OE_O(st_oe), .LOAD_DONE_O(), .LOAD_DONE_OE_O(dn_oe),
        .CFG_DATA_O(data_o), .CFG_DATA_OE_O(data_oe), .USER_IO_EN_O(uio),
        .USER_MODE_O(umode), .CFG_CLK_O(), .CFG_CLK_OE_O(clk_oe),
        .CFG_BYTE_O(cfg_byte), .CFG_BYTE_VLD_O(vld), .TDO_O(tdo),
        .TDO_OE_O(tdo_oe));
    cfg_host i_host (.status_i(~st_oe), .bclk_o(bclk), .data_o(data));
    // core clock at 100 MHz; user init clock runs free at half rate
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) uclk <= ~uclk;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // mode select and data settle four core cycles before each rise
    task automatic tap(input logic m, input logic d);
        tms = m;
        tdi = d;
        cyc(4);
        tck = 1'b1;
        cyc(4);
        tck = 1'b0;
    endtask
    task automatic chk(input logic [8:0] seen, input logic [8:0] want);
        samples_checked++;
        if (seen !== want) begin
            n_errors++;
            $display("ERROR %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic print_verdict();
        $display("checked %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // captured byte settles well inside one 6 ns link period
    always @(posedge bclk) begin
        #1;
        if (exp_q.size() > 0)
            chk({vld, cfg_byte}, exp_q.pop_front());
    end
    // watchdog: user clock init needs some 6,400 core cycles, plus margin
    initial begin
        #100000;
        n_errors++;
        print_verdict();
    end
    initial begin
        rst = 1'b1; req_n = 1'b1; uclk = 1'b0; udata = 8'h00;
        n_errors = 0; samples_checked = 0;
        tck = 1'b0;
        tms = 1'b0;
        tdi = 1'b0;
        use_uclk = 1'b0;
        dual = 1'b1;
        rnd = lfsr(32'hA545);
        sel = rnd[2:0]; // any scheme code; the parallel load must not care
        cyc(8);
        rst = 1'b0;
        cyc(18);
        chk(st_oe, 1'b1);
        chk(dn_oe, 1'b1);
        $display("test power-on done");
        wait (st_oe === 1'b0);
        cyc(5);
        for (int k = 1; k <= 8; k++) begin
            cyc(1);
            rnd = lfsr(rnd);
            last = rnd[7:0];
            exp_q.push_back({1'b1, last});
            i_host.send(last);
            if (k < 7) chk(dn_oe, 1'b1);
            if (k == 7) begin
                cyc(6);
                chk(dn_oe, 1'b0);
            end
        end
        // refused extra byte adds no falling edge; the last byte gave the second
        exp_q.push_back({1'b0, last});
        i_host.send(~last);
        $display("test load done");
        cyc(1);
        udata = rnd[15:8];
        cyc(20);
        chk(umode, 1'b0);
        cyc(40);
        chk(umode, 1'b1);
        chk(uio, 1'b1);
        chk(data_oe, 8'hFF);
        chk(data_o, udata);
        chk({st_oe, dn_oe}, 8'h00);
        $display("test init done");
        // request held low for 600 ns
        req_n = 1'b0;
        sel = cfg_load_pkg::SEL_ACTIVE_SERIAL;
        cyc(6);
        chk(dn_oe, 1'b1);
        chk(umode, 1'b0);
        cyc(54);
        chk(st_oe, 1'b1);
        req_n = 1'b1;
        cyc(8);
        chk(st_oe, 1'b0);
        chk(dn_oe, 1'b1);
        chk(clk_oe, 1'b1);
        $display("test reconfig done");
        // scan load code into the instruction register, LSB first
        tap(1'b0, 1'b0);
        tap(1'b1, 1'b0);
        tap(1'b1, 1'b0);
        tap(1'b0, 1'b0);
        tap(1'b0, 1'b0);
        cyc(4);
        chk({tdo_oe, tdo}, 2'h3);
        tap(1'b0, 1'b0);
        tap(1'b0, 1'b1);
        tap(1'b0, 1'b0);
        tap(1'b1, 1'b0);
        tap(1'b1, 1'b0);
        tap(1'b0, 1'b0);
        cyc(2);
        chk(dn_oe, 1'b1);
        chk(clk_oe, 1'b0);
        chk({uio, data_oe}, 9'h000);
        chk(tdo_oe, 1'b0);
        $display("test scan load done");
        // leave through test logic reset; init now timed by the user clock
        use_uclk = 1'b1;
        dual = 1'b0;
        repeat (4) tap(1'b1, 1'b0);
        cyc(2 * cfg_load_pkg::USER_INIT_EDGES - 20);
        chk(umode, 1'b0);
        cyc(40);
        chk(umode, 1'b1);
        chk(data_oe, 8'h00);
        chk(dn_oe, 1'b0);
        $display("test user clock init done");
        print_verdict();
    end
endmodule
